// [common/wdt_pkg.sv]
// Constants shared by the watchdog core and its tick prescaler.
// Assumes one 50 MHz system clock and a byte-wide register port.
package wdt_pkg;

    ////////////////////////////////////////////////////////////////////
    // Clock and divider figures
    localparam int CLK_MHZ     = 50;
    localparam int PRE_W       = 13;           // Widest division 8192
    localparam int DIV_MIN_LOG = 6;            // Narrowest division 64
    localparam int N_DIV       = 8;
    localparam int OSC_DIV     = 4;            // Oscillator model divider
    localparam int OSC_W       = 2;

    ////////////////////////////////////////////////////////////////////
    // Register port
    localparam int ADDR_W = 2;
    localparam logic [ADDR_W-1:0] ADDR_CSR = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_CNT = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_SEL = 2'h2;

    ////////////////////////////////////////////////////////////////////
    // Control/status field positions
    localparam int B_CWE_INH = 7;
    localparam int B_CWE     = 6;
    localparam int B_RWE_INH = 5;
    localparam int B_RWE     = 4;
    localparam int B_RUN_INH = 3;
    localparam int B_RUN     = 2;
    localparam int B_FLG_INH = 1;
    localparam int B_FLG     = 0;
    localparam int B_OSC_SEL = 3;              // Select code top bit

    ////////////////////////////////////////////////////////////////////
    // Reset values and fixed patterns
    localparam logic [7:0] CNT_RST   = 8'h00;
    localparam logic [7:0] CNT_MAX   = 8'hff;
    localparam logic [3:0] SEL_RST   = 4'hf;
    localparam logic [3:0] SEL_UPPER = 4'hf;
    localparam logic [7:0] RD_NONE   = 8'h00;
    localparam logic [7:0] PULSE_END = 8'hff;  // 256 oscillator ticks

    typedef enum logic [1:0] {
        ST_COUNT = 2'b01,
        ST_PULSE = 2'b10
    } wdt_state_t;

endpackage

// [core/wdt_prescale.sv]
// Tick prescaler: system clock divisions and oscillator model.
// Assumes the core takes one-cycle enable pulses, no second clock.
`timescale 1ns/1ns
module wdt_prescale
    import wdt_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Control
    input  wire logic [3:0] sel_i,
    input  wire logic       standby_i,
    // Ticks
    output logic            tick_o,
    output logic            osc_tick_o
);

    logic [PRE_W-1:0] pre;
    logic [OSC_W-1:0] osc;
    logic [N_DIV-1:0] div_tick;

    ////////////////////////////////////////////////////////////////////
    // Free-running divider chain; halted in standby like the bus clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre <= '0;
        end else if (!standby_i) begin
            pre <= pre + 1'b1;
        end
    end

    // Oscillator model keeps running in every mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc        <= '0;
            osc_tick_o <= 1'b0;
        end else begin
            osc        <= (osc == OSC_W'(OSC_DIV - 1)) ? '0 : osc + 1'b1;
            osc_tick_o <= (osc == OSC_W'(OSC_DIV - 1));
        end
    end

    // One tick per division: low bits all ones
    genvar g;
    generate
        for (g = 0; g < N_DIV; g++) begin : g_div
            assign div_tick[g] = !standby_i &&
                (&pre[DIV_MIN_LOG+g-1:0]);
        end
    endgenerate

    // Selected source, registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_o <= 1'b0;
        end else if (sel_i[B_OSC_SEL]) begin
            tick_o <= div_tick[sel_i[2:0]];
        end else begin
            tick_o <= osc_tick_o;
        end
    end

endmodule

// [core/wdt_core.sv]
// Eight-bit watchdog: counter, guarded control/status, reset pulse.
// Assumes a byte register port with one-cycle strobes and that
// RST_I is the external reset pin of the chip.
//
// What this block does
// - Nine count sources: eight divisions, oscillator
// - Oscillator source counts in every mode
// - Overflow raises internal reset; period 1..256
// - Enabled and counting straight out of reset
// - Bit 7 reads 1; guards bit 6
// - Counter write enable resets 0, gates counter writes
// - Bit 5 reads 1; guards bit 4
// - Register write enable resets 0, gates run/flag
// - Bit 3 reads 1; guards run bit
// - Run bit resets 1; counts when set
// - Run bit set or cleared by guarded write
// - Bit 1 reads 1; guards flag
// - Overflow sets flag; own reset keeps it
// - Flag cleared by pin reset or write
// - Eight-bit up-counter, zero start, wraps
// - Internal reset lasts 256 oscillator ticks
// - Select resets 1111; 0XXX picks oscillator
`timescale 1ns/1ns
module wdt_core
    import wdt_pkg::*;
(
    // Clock and reset
    input  wire logic              SYS_CLK_I,
    input  wire logic              RST_I,
    // Chip mode
    input  wire logic              STANDBY_I,
    // Register port
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic [7:0]        WR_DATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    output logic      [7:0]        RD_DATA_O,
    // Chip-wide reset request
    output logic                   WDT_RESET_O
);

    ////////////////////////////////////////////////////////////////////
    // State

    wdt_state_t state;
    logic [7:0] watchdog_up_counter;
    logic [3:0] clock_select_field;
    logic       counter_write_enable;
    logic       reg_write_enable;
    logic       run_enable;
    logic       overflow_reset_flag;
    logic [7:0] pulse_cnt;
    logic       tick;
    logic       osc_tick;

    // Decoded strobes
    logic       wr_csr;
    logic       wr_cnt;
    logic       wr_sel;
    logic       cnt_load;
    logic       ovf;
    logic       pulse_done;
    logic       in_pulse;

    ////////////////////////////////////////////////////////////////////
    // Tick source

    wdt_prescale u_pre (
        .clk_i      (SYS_CLK_I),
        .rst_i      (RST_I),
        .sel_i      (clock_select_field),
        .standby_i  (STANDBY_I),
        .tick_o     (tick),
        .osc_tick_o (osc_tick)
    );

    ////////////////////////////////////////////////////////////////////
    // Decode

    // Guard test: the inhibit bit must be written as 0
    function automatic logic guard_open(input logic [7:0] d,
                                        input int inh);
        guard_open = !d[inh];
    endfunction

    // Writes are dropped while the chip is held in watchdog reset
    assign in_pulse   = (state == ST_PULSE);
    assign wr_csr     = WR_I && !in_pulse && (ADDR_I == ADDR_CSR);
    assign wr_cnt     = WR_I && !in_pulse && (ADDR_I == ADDR_CNT);
    assign wr_sel     = WR_I && !in_pulse && (ADDR_I == ADDR_SEL);
    assign cnt_load   = wr_cnt && counter_write_enable;
    // Write wins over an increment in the same cycle
    assign ovf        = !in_pulse && run_enable && tick &&
                        !cnt_load &&
                        (watchdog_up_counter == CNT_MAX);
    assign pulse_done = in_pulse && osc_tick &&
                        (pulse_cnt == PULSE_END);

    ////////////////////////////////////////////////////////////////////
    // Sequencer: counting, then a fixed internal reset pulse

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            state <= ST_COUNT;
        end else begin
            case (state)
                ST_COUNT: begin
                    if (ovf) begin
                        state <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    if (pulse_done) begin
                        state <= ST_COUNT;
                    end
                end
                default: begin
                    state <= ST_COUNT;
                end
            endcase
        end
    end

    // Pulse length counted in oscillator ticks, not system cycles
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || !in_pulse) begin
            pulse_cnt <= CNT_RST;
        end else if (osc_tick) begin
            pulse_cnt <= pulse_cnt + 1'b1;
        end
    end

    // Reset output follows the sequencer, registered
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            WDT_RESET_O <= 1'b0;
        end else begin
            WDT_RESET_O <= (ovf || in_pulse) && !pulse_done;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Counter

    // Preload sets the period; internal reset returns it to zero
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || in_pulse) begin
            watchdog_up_counter <= CNT_RST;
        end else if (cnt_load) begin
            watchdog_up_counter <= WR_DATA_I;
        end else if (run_enable && tick) begin
            watchdog_up_counter <= watchdog_up_counter + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Clock select

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || in_pulse) begin
            clock_select_field <= SEL_RST;
        end else if (wr_sel) begin
            clock_select_field <= WR_DATA_I[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Guarded control/status bits; a bit-set instruction would
    // write back the inhibit bits as 1 and change nothing

    // Counter write enable
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || in_pulse) begin
            counter_write_enable <= 1'b0;
        end else if (wr_csr && guard_open(WR_DATA_I, B_CWE_INH)) begin
            counter_write_enable <= WR_DATA_I[B_CWE];
        end
    end

    // Register write enable
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || in_pulse) begin
            reg_write_enable <= 1'b0;
        end else if (wr_csr && guard_open(WR_DATA_I, B_RWE_INH)) begin
            reg_write_enable <= WR_DATA_I[B_RWE];
        end
    end

    // Run bit: needs the enable already set, hence two writes to stop
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || in_pulse) begin
            run_enable <= 1'b1;
        end else if (wr_csr && reg_write_enable &&
                     guard_open(WR_DATA_I, B_RUN_INH)) begin
            run_enable <= WR_DATA_I[B_RUN];
        end
    end

    // Flag: only the pin reset clears it by reset; set beats clear
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            overflow_reset_flag <= 1'b0;
        end else if (ovf) begin
            overflow_reset_flag <= 1'b1;
        end else if (wr_csr && reg_write_enable &&
                     guard_open(WR_DATA_I, B_FLG_INH) &&
                     !WR_DATA_I[B_FLG]) begin
            overflow_reset_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read port: data valid the cycle after the strobe

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            RD_DATA_O <= RD_NONE;
        end else if (RD_I) begin
            case (ADDR_I)
                ADDR_CSR: begin
                    RD_DATA_O <= {1'b1, counter_write_enable,
                                  1'b1, reg_write_enable,
                                  1'b1, run_enable,
                                  1'b1, overflow_reset_flag};
                end
                ADDR_CNT: begin
                    RD_DATA_O <= watchdog_up_counter;
                end
                ADDR_SEL: begin
                    RD_DATA_O <= {SEL_UPPER, clock_select_field};
                end
                default: begin
                    RD_DATA_O <= RD_NONE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_csr_rd;
        RD_I && (ADDR_I == ADDR_CSR);
    endsequence

    sequence s_overflow;
        ovf;
    endsequence

    sequence s_pulse_end;
        pulse_done;
    endsequence

    // Inhibit bits always read as 1
    property p_fixed_ones;
        s_csr_rd |=> (RD_DATA_O[B_CWE_INH] && RD_DATA_O[B_RWE_INH] &&
                      RD_DATA_O[B_RUN_INH] && RD_DATA_O[B_FLG_INH]);
    endproperty
    a_fixed_ones: assert property (p_fixed_ones)
        else $error("inhibit bit read as 0");

    // A closed guard leaves the counter write enable alone
    property p_cwe_guard;
        (wr_csr && WR_DATA_I[B_CWE_INH])
            |=> $stable(counter_write_enable);
    endproperty
    a_cwe_guard: assert property (p_cwe_guard)
        else $error("counter write enable changed behind guard");

    // Enabled counter write lands exactly
    property p_cnt_load;
        cnt_load |=> (watchdog_up_counter == $past(WR_DATA_I));
    endproperty
    a_cnt_load: assert property (p_cnt_load)
        else $error("counter write lost");

    // Run bit only moves through its own open guard and enable
    property p_run_guard;
        (wr_csr && (!reg_write_enable || WR_DATA_I[B_RUN_INH]))
            |=> $stable(run_enable);
    endproperty
    a_run_guard: assert property (p_run_guard)
        else $error("run bit changed behind guard");

    // Stopped counter holds unless written
    property p_hold;
        (!run_enable && !cnt_load && !in_pulse)
            |=> $stable(watchdog_up_counter);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counter moved while stopped");

    // Overflow raises reset and flag on the next edge
    property p_overflow;
        s_overflow |=> (WDT_RESET_O && overflow_reset_flag &&
                        in_pulse);
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow did not raise reset and flag");

    // Pulse ends only after the last of 256 ticks; a pin reset that
    // cut the pulse is excluded, it drops the output on its own
    property p_pulse_len;
        $fell(WDT_RESET_O) && !$past(RST_I) |-> $past(pulse_done);
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("internal reset ended early");

    // Pulse end releases reset and restores run defaults
    property p_pulse_exit;
        s_pulse_end |=> (!WDT_RESET_O && run_enable &&
                         !reg_write_enable && state == ST_COUNT);
    endproperty
    a_pulse_exit: assert property (p_pulse_exit)
        else $error("bad state after internal reset");

    // Guarded write of 0 clears the flag
    property p_flag_clear;
        (wr_csr && reg_write_enable && !WR_DATA_I[B_FLG_INH] &&
         !WR_DATA_I[B_FLG] && !ovf) |=> !overflow_reset_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag not cleared");

endmodule

// [testbench/test_watchdog_timer_8bit.sv]
// Self-checking bench for the eight-bit watchdog core.
// Assumes the register map of wdt_pkg and a 50 MHz system clock.
`timescale 1ns/1ns
module test_watchdog_timer_8bit;
    import wdt_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Signals and counters
    logic              sys_clk;
    logic              rst;
    logic              standby;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wr_data;
    logic              wr;
    logic              rd;
    logic [7:0]        rd_data;
    logic              wdt_reset;
    int                err_count;
    int                samples_checked;
    int                cycles;
    int                n;

    // Rows: {write, address, write byte, expected read byte}
    localparam logic [18:0] ROWS [18] = '{
        {1'b0, ADDR_CSR, 8'h00, 8'hae}, {1'b0, ADDR_SEL, 8'h00, 8'hff},
        {1'b0, ADDR_CNT, 8'h00, 8'h00}, {1'b0, 2'h3,     8'h00, 8'h00},
        {1'b1, ADDR_CNT, 8'h55, 8'h00}, {1'b0, ADDR_CNT, 8'h00, 8'h00},
        {1'b1, ADDR_CSR, 8'h7f, 8'h00}, {1'b0, ADDR_CSR, 8'h00, 8'hee},
        {1'b1, ADDR_CNT, 8'h55, 8'h00}, {1'b0, ADDR_CNT, 8'h00, 8'h55},
        {1'b1, ADDR_CSR, 8'hf3, 8'h00}, {1'b0, ADDR_CSR, 8'h00, 8'hee},
        {1'b1, ADDR_CSR, 8'hdf, 8'h00}, {1'b0, ADDR_CSR, 8'h00, 8'hfe},
        {1'b1, ADDR_CSR, 8'h33, 8'h00}, {1'b0, ADDR_CSR, 8'h00, 8'hba},
        {1'b1, ADDR_SEL, 8'h08, 8'h00}, {1'b0, ADDR_SEL, 8'h00, 8'hf8}
    };

    ////////////////////////////////////////////////////////////////////
    // Clock and device under test
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    wdt_core dut (
        .SYS_CLK_I   (sys_clk),
        .RST_I       (rst),
        .STANDBY_I   (standby),
        .ADDR_I      (addr),
        .WR_DATA_I   (wr_data),
        .WR_I        (wr),
        .RD_I        (rd),
        .RD_DATA_O   (rd_data),
        .WDT_RESET_O (wdt_reset)
    );

    ////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t ns: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // One-cycle write strobe; the edge after the call takes it
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        addr    <= a;
        wr_data <= d;
        wr      <= 1'b1;
        @(posedge sys_clk);
        wr      <= 1'b0;
        // Step off the edge so a following call never re-raises wr here
        #1;
    endtask

    // Read data stand from the cycle after the strobe until the next read strobe
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        #1;
        chk(rd_data, exp);
    endtask

    // Bounded wait for the reset request to reach a level
    task automatic wait_level(input logic lvl, input int lim,
                              output int cnt);
        cnt = 0;
        while (wdt_reset !== lvl && cnt < lim) begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Hang guard: the whole run needs under two thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 12000) begin
            err_count++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        standby = 1'b0;
        addr = '0;
        wr_data = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        err_count = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;

        // Table of plain register accesses
        foreach (ROWS[i]) begin
            if (ROWS[i][18])
                wr_reg(ROWS[i][17:16], ROWS[i][15:8]);
            else
                rd_reg(ROWS[i][17:16], ROWS[i][7:0]);
        end
        $display("register table done");

        // Stopped counter must hold through several divided ticks
        repeat (200) @(posedge sys_clk);
        rd_reg(ADDR_CNT, 8'h55);
        wr_reg(ADDR_CSR, 8'h77);
        rd_reg(ADDR_CSR, 8'hfe);
        wr_reg(ADDR_CNT, 8'hfe);
        wait_level(1'b1, 300, n);
        chk(8'(n >= 62 && n <= 132), 8'h01);
        wait_level(1'b0, 2000, n);
        chk(8'(n >= 256 * OSC_DIV - OSC_DIV - 1 &&
               n <= 256 * OSC_DIV + OSC_DIV + 1), 8'h01);
        $display("divided overflow done");

        // Own reset keeps the flag; other fields reinitialised
        rd_reg(ADDR_CSR, 8'haf);
        rd_reg(ADDR_SEL, 8'hff);
        wr_reg(ADDR_CSR, 8'hdf);
        wr_reg(ADDR_CSR, 8'hfe);
        rd_reg(ADDR_CSR, 8'hbf);
        wr_reg(ADDR_CSR, 8'hfc);
        rd_reg(ADDR_CSR, 8'hbe);
        $display("flag handling done");

        // Oscillator source keeps counting in low-power mode
        standby <= 1'b1;
        wr_reg(ADDR_SEL, 8'h00);
        rd_reg(ADDR_SEL, 8'hf0);
        wr_reg(ADDR_CSR, 8'h7f);
        wr_reg(ADDR_CNT, 8'hf0);
        wait_level(1'b1, 200, n);
        chk(8'(n >= 15 * OSC_DIV && n <= 16 * OSC_DIV + 4), 8'h01);
        $display("oscillator overflow done");

        // Pin reset in mid-pulse clears the flag and restarts counting
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst     <= 1'b0;
        standby <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk({7'h00, wdt_reset}, 8'h00);
        rd_reg(ADDR_CSR, 8'hae);
        // Divide by 128: exactly one tick lands before the counter read
        wr_reg(ADDR_SEL, 8'h09);
        repeat (140) @(posedge sys_clk);
        #1;
        chk(rd_data, 8'hae);
        rd_reg(ADDR_CNT, 8'h01);
        $display("pin reset done");
        print_verdict();
    end

endmodule
